// *** core/pllcfg_bank.sv ***
// Eight-byte configuration register bank of the PLL clock generator.
//
// Contract
// - Two power-down bits, 13 and 53, each one powers its section down.
// - Bit 48 enables the sync function when one.
// - Bit 49 picks the sync edge: zero negative, one positive.
// - Bit 39 picks the output pair drive: zero PECL, one CMOS.
// - Bit 38 feeds the feedback divider: zero VCO, one post divider.
// - Bit 12 feeds the reference divider: zero crystal, one pin.
// - Feedback modulus is binary bits 37 down to 24.
// - Reference modulus is binary bits 11 down to 0.
// - Post dividers one and two divide by code plus one; codes 0-11.
// - Post divider three divides by 1, 2, 4 or 8 from bits 15:14.
// - Bits 41:40 pick pump current, rising; code 10 is 11.0 uA.
// - Bits 45:44 pick filter resistor, falling; code 10 is 30 kohm.
// - Bit 46 picks filter capacitor: 185 pF or 500 pF.
// - All bits clear at reset and read back as last written.
// - Each written byte takes effect at its own acknowledge.
// - Pointer steps by one after each byte, wrapping past the top.
`timescale 1ns/10ps
module pllcfg_bank
	import pllcfg_pkg::*;
#(
	parameter int unsigned NUM_REGS = REG_COUNT
)
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  pllcfg_req_type        host_req,
	input  wire logic             flag_clear,
	output logic      [7:0]       rd_data,
	output logic      [ADDR_W-1:0] cur_ptr,
	output logic      [7:0]       byte_updated,
	output logic                  rsvd_write_seen,
	output logic                  post_range_seen,
	output logic                  ref_modulus_settled,
	output logic                  fb_modulus_settled,
	output logic      [BANK_W-1:0] bank_image,
	output pllcfg_fields_type     fields,
	output pllcfg_ratio_type      ratios
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (NUM_REGS != REG_COUNT)
	begin : g_size_check
		$error("The bank must hold exactly eight byte registers.");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0][7:0] bank_ff;
		logic [7:0]      rd_data_ff;
		logic [7:0]      byte_upd_ff;
		logic            rsvd_err_ff;
		logic            post_err_ff;
		logic            ref_pend_ff;
		logic            fb_pend_ff;
	} pllcfg_bank_state_type;

	pllcfg_bank_state_type st_ff;
	pllcfg_bank_state_type nxt_st;

	logic [ADDR_W-1:0] ptr;
	logic              wr_fire;
	logic              rd_fire;
	logic [7:0]        rsvd_byte_mask;
	logic              rsvd_hit;
	logic              post_hit;
	logic [7:0][7:0]   rsvd_bytes;

	assign rsvd_bytes = RSVD_MASK;

	// ****************************************************************
	// Byte access decode
	// ****************************************************************
	// A pointer load takes the whole cycle; a data byte in the same cycle
	// as a load is ignored, since the address phase precedes any data.
	always_comb
	begin
		wr_fire = host_req.wr_en && !host_req.ptr_load;
		rd_fire = host_req.rd_ack && !host_req.ptr_load && !wr_fire;
	end

	pllcfg_ptr u_ptr
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.load      (host_req.ptr_load),
		.load_addr (host_req.ptr_addr),
		.step      (wr_fire || rd_fire),
		.ptr       (ptr)
	);

	// ****************************************************************
	// Host misuse detection
	// ****************************************************************
	// The host is expected to keep reserved bits zero and post codes
	// in range; the bank still stores what is written so that readback
	// stays exact, and only raises a sticky flag for software to see.
	always_comb
	begin
		rsvd_byte_mask = rsvd_bytes[ptr];
		rsvd_hit = wr_fire && |(host_req.wr_data & rsvd_byte_mask);
		post_hit = 1'b0;
		if (wr_fire && ptr == REG_POST_DIVIDER_MODULI)
		begin
			post_hit = (host_req.wr_data[3:0] > POST_MAX_CODE) ||
				(host_req.wr_data[7:4] > POST_MAX_CODE);
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.byte_upd_ff = 8'h00;

		// Each byte lands on the cycle it is acknowledged.
		if (wr_fire)
		begin
			nxt_st.bank_ff[ptr] = host_req.wr_data;
			nxt_st.byte_upd_ff[ptr] = 1'b1;
		end

		// Read data follows the pointer, which after a write is the byte above the one written.
		if (wr_fire)
		begin
			nxt_st.rd_data_ff = nxt_st.bank_ff[ADDR_W'(ptr + 1'b1)];
		end
		else if (host_req.ptr_load)
		begin
			nxt_st.rd_data_ff = st_ff.bank_ff[host_req.ptr_addr];
		end
		else if (rd_fire)
		begin
			nxt_st.rd_data_ff = st_ff.bank_ff[ADDR_W'(ptr + 1'b1)];
		end
		else
		begin
			nxt_st.rd_data_ff = st_ff.bank_ff[ptr];
		end

		// Sticky flags: a new event in the clear cycle survives.
		if (flag_clear)
		begin
			nxt_st.rsvd_err_ff = 1'b0;
			nxt_st.post_err_ff = 1'b0;
		end
		if (rsvd_hit)
		begin
			nxt_st.rsvd_err_ff = 1'b1;
		end
		if (post_hit)
		begin
			nxt_st.post_err_ff = 1'b1;
		end

		// Multi-byte moduli: each write to either half toggles the pair's
		// pending flag, so any second write, even to the same half, settles it.
		if (wr_fire)
		begin
			case (ptr)
				REG_REF_DIVIDER_LOW,
				REG_REF_DIVIDER_HIGH_AND_CONTROLS:
				begin
					nxt_st.ref_pend_ff = !st_ff.ref_pend_ff;
				end
				REG_FEEDBACK_DIVIDER_LOW,
				REG_FEEDBACK_DIVIDER_HIGH_AND_OUTPUT:
				begin
					nxt_st.fb_pend_ff = !st_ff.fb_pend_ff;
				end
				default:
				begin
					nxt_st.ref_pend_ff = st_ff.ref_pend_ff;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff.bank_ff     <= BANK_RESET;
			st_ff.rd_data_ff  <= 8'h00;
			st_ff.byte_upd_ff <= 8'h00;
			st_ff.rsvd_err_ff <= 1'b0;
			st_ff.post_err_ff <= 1'b0;
			st_ff.ref_pend_ff <= 1'b0;
			st_ff.fb_pend_ff  <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Field outputs
	// ****************************************************************
	// Fields are pure decode of the bank flops, so they move only when
	// a byte is written or reset clears the bank.
	pllcfg_field_map u_map
	(
		.bank   (st_ff.bank_ff),
		.fields (fields),
		.ratios (ratios)
	);

	assign rd_data             = st_ff.rd_data_ff;
	assign cur_ptr             = ptr;
	assign byte_updated        = st_ff.byte_upd_ff;
	assign rsvd_write_seen     = st_ff.rsvd_err_ff;
	assign post_range_seen     = st_ff.post_err_ff;
	assign ref_modulus_settled = !st_ff.ref_pend_ff;
	assign fb_modulus_settled  = !st_ff.fb_pend_ff;
	assign bank_image          = st_ff.bank_ff;

endmodule : pllcfg_bank

// *** core/pllcfg_pkg.sv ***
// Constants and types shared by the PLL configuration register bank.
package pllcfg_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned REG_COUNT   = 8;
	localparam int unsigned ADDR_W      = 3;
	localparam int unsigned BANK_W      = 64;
	localparam logic [2:0]  REG_REF_DIVIDER_LOW                = 3'h0;
	localparam logic [2:0]  REG_REF_DIVIDER_HIGH_AND_CONTROLS  = 3'h1;
	localparam logic [2:0]  REG_POST_DIVIDER_MODULI            = 3'h2;
	localparam logic [2:0]  REG_FEEDBACK_DIVIDER_LOW           = 3'h3;
	localparam logic [2:0]  REG_FEEDBACK_DIVIDER_HIGH_AND_OUTPUT = 3'h4;
	localparam logic [2:0]  REG_LOOP_TUNING                    = 3'h5;
	localparam logic [2:0]  REG_POWER_AND_SYNC_CONTROL         = 3'h6;
	localparam logic [2:0]  REG_RESERVED_TOP                   = 3'h7;
	localparam logic [63:0] BANK_RESET  = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RSVD_MASK   = 64'hFFDC_8C00_0000_0000;

	// ****************************************************************
	// Field positions and widths
	// ****************************************************************
	localparam int unsigned REF_MOD_LSB   = 0;
	localparam int unsigned REF_MOD_W     = 12;
	localparam int unsigned REF_SRC_BIT   = 12;
	localparam int unsigned PD_A_BIT      = 13;
	localparam int unsigned POST_MODULUS_THREE_LSB     = 14;
	localparam int unsigned POST_MODULUS_ONE_LSB     = 16;
	localparam int unsigned POST_MODULUS_TWO_LSB     = 20;
	localparam int unsigned FB_MOD_LSB    = 24;
	localparam int unsigned FB_MOD_W      = 14;
	localparam int unsigned FB_SRC_BIT    = 38;
	localparam int unsigned OUT_MODE_BIT  = 39;
	localparam int unsigned PUMP_LSB      = 40;
	localparam int unsigned RES_LSB       = 44;
	localparam int unsigned CAP_BIT       = 46;
	localparam int unsigned SYNC_EN_BIT   = 48;
	localparam int unsigned SYNC_EDGE_BIT = 49;
	localparam int unsigned PD_B_BIT      = 53;
	localparam logic [3:0]  POST_MAX_CODE = 4'hB;

	// ****************************************************************
	// Analog tuning tables, indexed by code
	// ****************************************************************
	localparam logic [14:0] PUMP_NA [0:3] =
		'{15'h07D0, 15'h1194, 15'h2AF8, 15'h57E4};
	localparam logic [18:0] RES_OHM [0:3] =
		'{19'h61A80, 19'h20788, 19'h07530, 19'h02EE0};
	localparam logic [8:0]  CAP_PF  [0:1] = '{9'h0B9, 9'h1F4};

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic {REF_XTAL = 1'b0, REF_PIN = 1'b1} pllcfg_ref_src_type;
	typedef enum logic {FB_VCO = 1'b0, FB_POST = 1'b1} pllcfg_fb_src_type;
	typedef enum logic {OUT_PECL = 1'b0, OUT_CMOS = 1'b1} pllcfg_out_type;
	typedef enum logic {EDGE_NEG = 1'b0, EDGE_POS = 1'b1} pllcfg_edge_type;

	typedef struct packed {
		logic        ptr_load;
		logic [2:0]  ptr_addr;
		logic        wr_en;
		logic [7:0]  wr_data;
		logic        rd_ack;
	} pllcfg_req_type;

	typedef struct packed {
		logic [11:0]        reference_modulus;
		pllcfg_ref_src_type reference_source_select;
		logic               power_down_a;
		logic [1:0]         post_modulus_three;
		logic [3:0]         post_modulus_one;
		logic [3:0]         post_modulus_two;
		logic [13:0]        feedback_modulus;
		pllcfg_fb_src_type  feedback_source_select;
		pllcfg_out_type     output_mode;
		logic [1:0]         pump_current_code;
		logic [1:0]         filter_resistor_code;
		logic               filter_capacitor_code;
		logic               sync_enable_bit;
		pllcfg_edge_type    sync_edge_select;
		logic               power_down_b;
	} pllcfg_fields_type;

	typedef struct packed {
		logic [3:0]  post_ratio_one;
		logic [3:0]  post_ratio_two;
		logic [3:0]  post_ratio_three;
		logic [14:0] pump_current_na;
		logic [18:0] resistor_ohm;
		logic [8:0]  capacitor_pf;
	} pllcfg_ratio_type;

endpackage : pllcfg_pkg

// *** core/pllcfg_ptr.sv ***
// Register address pointer with load and wrapping increment.
`timescale 1ns/10ps
module pllcfg_ptr
	import pllcfg_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             load,
	input  wire logic [ADDR_W-1:0] load_addr,
	input  wire logic             step,
	output logic      [ADDR_W-1:0] ptr
);

	typedef struct packed {
		logic [ADDR_W-1:0] ptr_ff;
	} pllcfg_ptr_state_type;

	pllcfg_ptr_state_type st_ff;
	pllcfg_ptr_state_type nxt_st;

	// ****************************************************************
	// Next pointer: a load wins over a step; a step wraps past the top.
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		if (load)
		begin
			nxt_st.ptr_ff = load_addr;
		end
		else if (step)
		begin
			nxt_st.ptr_ff = ADDR_W'(st_ff.ptr_ff + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign ptr = st_ff.ptr_ff;

endmodule : pllcfg_ptr

// *** core/pllcfg_field_map.sv ***
// Unpacks the configuration image into named fields and decoded values.
`timescale 1ns/10ps
module pllcfg_field_map
	import pllcfg_pkg::*;
(
	input  wire logic [BANK_W-1:0] bank,
	output pllcfg_fields_type      fields,
	output pllcfg_ratio_type       ratios
);

	function automatic logic [3:0] post_ratio(input logic [3:0] code);
		post_ratio = 4'(code + 4'h1);
	endfunction : post_ratio

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	always_comb
	begin
		fields.reference_modulus = bank[REF_MOD_LSB +: REF_MOD_W];
		fields.reference_source_select =
			pllcfg_ref_src_type'(bank[REF_SRC_BIT]);
		fields.power_down_a = bank[PD_A_BIT];
		fields.post_modulus_three = bank[POST_MODULUS_THREE_LSB +: 2];
		fields.post_modulus_one = bank[POST_MODULUS_ONE_LSB +: 4];
		fields.post_modulus_two = bank[POST_MODULUS_TWO_LSB +: 4];
		fields.feedback_modulus = bank[FB_MOD_LSB +: FB_MOD_W];
		fields.feedback_source_select =
			pllcfg_fb_src_type'(bank[FB_SRC_BIT]);
		fields.output_mode = pllcfg_out_type'(bank[OUT_MODE_BIT]);
		fields.pump_current_code = bank[PUMP_LSB +: 2];
		fields.filter_resistor_code = bank[RES_LSB +: 2];
		fields.filter_capacitor_code = bank[CAP_BIT];
		fields.sync_enable_bit = bank[SYNC_EN_BIT];
		fields.sync_edge_select =
			pllcfg_edge_type'(bank[SYNC_EDGE_BIT]);
		fields.power_down_b = bank[PD_B_BIT];
	end

	// ****************************************************************
	// Decoded ratios and analog settings
	// ****************************************************************
	always_comb
	begin
		ratios.post_ratio_one = post_ratio(bank[POST_MODULUS_ONE_LSB +: 4]);
		ratios.post_ratio_two = post_ratio(bank[POST_MODULUS_TWO_LSB +: 4]);
		ratios.post_ratio_three =
			4'(4'h1 << bank[POST_MODULUS_THREE_LSB +: 2]);
		ratios.pump_current_na = PUMP_NA[bank[PUMP_LSB +: 2]];
		ratios.resistor_ohm = RES_OHM[bank[RES_LSB +: 2]];
		ratios.capacitor_pf = CAP_PF[bank[CAP_BIT]];
	end

endmodule : pllcfg_field_map

// *** tb/pllcfg_bank_assertions.sv ***
// Concurrent checks on the ports of the PLL configuration register bank.
`timescale 1ns/10ps
module pllcfg_bank_assertions
	import pllcfg_pkg::*;
#(
	parameter int unsigned NUM_REGS = REG_COUNT
)
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  pllcfg_req_type         host_req,
	input  wire logic              flag_clear,
	input  wire logic [7:0]        rd_data,
	input  wire logic [ADDR_W-1:0] cur_ptr,
	input  wire logic [7:0]        byte_updated,
	input  wire logic              rsvd_write_seen,
	input  wire logic              post_range_seen,
	input  wire logic              ref_modulus_settled,
	input  wire logic              fb_modulus_settled,
	input  wire logic [BANK_W-1:0] bank_image,
	input  pllcfg_fields_type      fields,
	input  pllcfg_ratio_type       ratios
);
	logic [63:0] b;
	logic        not_write;
	assign b = bank_image;
	assign not_write = !(host_req.wr_en && !host_req.ptr_load);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence load_s;
		host_req.ptr_load;
	endsequence
	sequence write_s;
		host_req.wr_en && !host_req.ptr_load;
	endsequence
	sequence ack_s;
		host_req.rd_ack && !host_req.wr_en && !host_req.ptr_load;
	endsequence
	sequence idle_s;
		!host_req.ptr_load && !host_req.wr_en && !host_req.rd_ack;
	endsequence

	ptr_load_a: assert property (
		load_s |=> cur_ptr == $past(host_req.ptr_addr))
		else $error("pointer not loaded");
	read_step_a: assert property (
		ack_s |=> cur_ptr == $past(cur_ptr) + 3'h1)
		else $error("pointer did not step after read");
	write_byte_a: assert property (
		write_s |=> b[8*$past(cur_ptr)+:8] == $past(host_req.wr_data)
		&& byte_updated == 8'h01 << $past(cur_ptr))
		else $error("written byte not applied at once");
	bank_hold_a: assert property (
		not_write |=> $stable(bank_image) && byte_updated == 8'h00)
		else $error("bank changed without a write");
	rd_track_a: assert property (
		idle_s ##1 idle_s |-> rd_data == b[8*cur_ptr+:8])
		else $error("read data differs from addressed byte");
	field_map_a: assert property (
		fields == {b[11:0], b[12], b[13], b[15:14], b[19:16], b[23:20],
		b[37:24], b[38], b[39], b[41:40], b[45:44], b[46], b[48], b[49],
		b[53]})
		else $error("field outputs differ from bank");
	post_ratio_a: assert property (
		ratios.post_ratio_one == b[19:16] + 4'h1
		&& ratios.post_ratio_two == b[23:20] + 4'h1
		&& ratios.post_ratio_three == 4'h1 << b[15:14])
		else $error("post divider ratio wrong");
	pump_code_a: assert property (
		b[41:40] == 2'h2 |-> ratios.pump_current_na == 15'h2AF8)
		else $error("pump current wrong");
	res_code_a: assert property (
		b[45:44] == 2'h2 |-> ratios.resistor_ohm == 19'h07530)
		else $error("filter resistor wrong");
	cap_sel_a: assert property (
		ratios.capacitor_pf == (b[46] ? 9'h1F4 : 9'h0B9))
		else $error("filter capacitor wrong");
	rsvd_flag_a: assert property (
		!not_write && |(host_req.wr_data & RSVD_MASK[8*cur_ptr+:8])
		|=> rsvd_write_seen)
		else $error("reserved write not flagged");
	post_flag_a: assert property (
		!not_write && cur_ptr == REG_POST_DIVIDER_MODULI
		&& (host_req.wr_data[3:0] > POST_MAX_CODE
		|| host_req.wr_data[7:4] > POST_MAX_CODE) |=> post_range_seen)
		else $error("post code out of range not flagged");
endmodule : pllcfg_bank_assertions

// *** tb/pllcfg_host.sv ***
// Host model issuing byte-level register requests to the bank.
`timescale 1ns/10ps
module pllcfg_host
	import pllcfg_pkg::*;
(
	input  wire logic     clk,
	output pllcfg_req_type host_req
);
	logic [2:0] p;
	logic       raw;
	initial
	begin
		host_req = '0;
		p = 3'h0;
		raw = 1'b0;
	end
	task automatic cyc(input logic ld, input logic [2:0] a, input logic we,
		input logic [7:0] d, input logic ra, output logic [7:0] sent);
		logic [7:0] v;
		v = d & ~RSVD_MASK[8*p+:8];
		if (p == REG_POST_DIVIDER_MODULI)
		begin
			if (v[3:0] > 4'hB) v[3:0] = 4'hB;
			if (v[7:4] > 4'hB) v[7:4] = 4'hB;
		end
		// A misbehaving host sends the byte unfiltered, to exercise the flags.
		if (raw) v = d;
		sent = v;
		@(posedge clk);
		#1;
		host_req = '{ptr_load: ld, ptr_addr: a, wr_en: we, wr_data: v,
			rd_ack: ra};
		if (ld) p = a;
		else if (we || ra) p = p + 3'h1;
	endtask : cyc
endmodule : pllcfg_host

// *** tb/pllcfg_bank_tb.sv ***
// Self-checking bench for the PLL configuration register bank.
`timescale 1ns/10ps
module pllcfg_bank_tb
	import pllcfg_pkg::*;
;
	logic              clk, rst_b, flag_clear;
	pllcfg_req_type    host_req;
	logic [7:0]        rd_data, byte_updated, sent;
	logic [2:0]        cur_ptr;
	logic              rsvd_s, post_s, ref_s, fb_s;
	logic [63:0]       bank_image;
	pllcfg_fields_type fields;
	pllcfg_ratio_type  ratios;
	logic [7:0]        mdl [8];
	logic [31:0]       seed;
	int                err_total, compares;
	int pump_na [4] = '{2000, 4500, 11000, 22500};
	int res_ohm [4] = '{400000, 133000, 30000, 12000};

	pllcfg_bank #(.NUM_REGS(8)) dut (.clk(clk), .rst_b(rst_b),
		.host_req(host_req), .flag_clear(flag_clear), .rd_data(rd_data),
		.cur_ptr(cur_ptr), .byte_updated(byte_updated),
		.rsvd_write_seen(rsvd_s), .post_range_seen(post_s),
		.ref_modulus_settled(ref_s), .fb_modulus_settled(fb_s),
		.bank_image(bank_image), .fields(fields), .ratios(ratios));
	pllcfg_host host (.clk(clk), .host_req(host_req));

	always #5 clk = ~clk;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic op(logic ld, logic [2:0] a, logic we, logic ra);
		host.cyc(ld, a, we, rnd(), ra, sent);
	endtask : op

	task automatic do_reset();
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		#1 rst_b = 1'b1;
		host.p = 3'h0;
		mdl = '{default: 8'h00};
	endtask : do_reset

	task automatic cmp_all();
		logic [63:0] m;
		m = {mdl[7], mdl[6], mdl[5], mdl[4], mdl[3], mdl[2], mdl[1], mdl[0]};
		chk("bank", bank_image, m);
		chk("fields", fields, {m[11:0], m[12], m[13], m[15:14], m[19:16],
			m[23:20], m[37:24], m[38], m[39], m[41:40], m[45:44], m[46],
			m[48], m[49], m[53]});
		chk("post_modulus_one", ratios.post_ratio_one, m[19:16] + 1);
		chk("post_modulus_two", ratios.post_ratio_two, m[23:20] + 1);
		chk("post_modulus_three", ratios.post_ratio_three, 1 << m[15:14]);
		chk("pump", ratios.pump_current_na, pump_na[m[41:40]]);
		chk("res", ratios.resistor_ohm, res_ohm[m[45:44]]);
		chk("cap", ratios.capacitor_pf, m[46] ? 500 : 185);
	endtask : cmp_all

	task automatic wb(logic [2:0] a, logic [7:0] d);
		op(1'b1, a, 1'b0, 1'b0);
		host.cyc(1'b0, 3'h0, 1'b1, d, 1'b0, sent);
		mdl[a] = sent;
		op(1'b0, 3'h0, 1'b0, 1'b0);
		chk("pulse", byte_updated, 8'h01 << a);
		chk("byte", bank_image[8*a+:8], mdl[a]);
	endtask : wb

	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial
	begin
		clk = 1'b0;
		flag_clear = 1'b0;
		seed = 40971;
		err_total = 0;
		compares = 0;
		do_reset();
		cmp_all();
		chk("ptr", cur_ptr, 0);
		chk("flags", {rsvd_s, post_s}, 2'b00);
		chk("settle", {ref_s, fb_s}, 2'b11);
		$display("test reset done");
		repeat (4)
		begin
			op(1'b1, 3'h0, 1'b0, 1'b0);
			for (int i = 0; i < 9; i++)
			begin
				if (i < 8) host.cyc(1'b0, 3'h0, 1'b1, rnd(), 1'b0, sent);
				else op(1'b0, 3'h0, 1'b0, 1'b0);
				if (i > 0) chk("pulse", byte_updated, 8'h01 << (i - 1));
				if (i == 1) chk("settle", {ref_s, fb_s}, 2'b01);
				if (i == 4) chk("settle", {ref_s, fb_s}, 2'b10);
				if (i < 8) mdl[i] = sent;
			end
			op(1'b0, 3'h0, 1'b0, 1'b0);
			cmp_all();
			chk("settle", {ref_s, fb_s}, 2'b11);
			chk("flags", {rsvd_s, post_s}, 2'b00);
			op(1'b1, 3'h5, 1'b0, 1'b0);
			for (int i = 0; i < 8; i++)
			begin
				op(1'b0, 3'h0, 1'b0, 1'b1);
				chk("rd", rd_data, mdl[(5 + i) % 8]);
			end
			op(1'b0, 3'h0, 1'b0, 1'b0);
			chk("ptr", cur_ptr, 5);
		end
		$display("test random done");
		for (int c = 0; c < 12; c++)
		begin
			wb(3'h1, {c[1:0], 6'h00});
			chk("refok", ref_s, c[0]);
			wb(3'h2, {c[3:0], c[3:0]});
			wb(3'h5, {1'b0, c[0], c[1:0], 2'b00, c[1:0]});
			cmp_all();
		end
		$display("test codes done");
		host.raw = 1'b1;
		wb(3'h7, 8'h80);
		chk("flags", {rsvd_s, post_s}, 2'b10);
		wb(3'h2, 8'hBC);
		chk("flags", {rsvd_s, post_s}, 2'b11);
		cmp_all();
		host.raw = 1'b0;
		flag_clear = 1'b1;
		op(1'b0, 3'h0, 1'b0, 1'b0);
		flag_clear = 1'b0;
		chk("flags", {rsvd_s, post_s}, 2'b00);
		$display("test misuse done");
		do_reset();
		cmp_all();
		chk("flags", {rsvd_s, post_s}, 2'b00);
		chk("settle", {ref_s, fb_s}, 2'b11);
		$display("test second reset done");
		results();
	end
endmodule : pllcfg_bank_tb

bind pllcfg_bank pllcfg_bank_assertions #(.NUM_REGS(NUM_REGS)) u_chk (
	.clk(clk), .rst_b(rst_b), .host_req(host_req),
	.flag_clear(flag_clear), .rd_data(rd_data), .cur_ptr(cur_ptr),
	.byte_updated(byte_updated), .rsvd_write_seen(rsvd_write_seen),
	.post_range_seen(post_range_seen),
	.ref_modulus_settled(ref_modulus_settled),
	.fb_modulus_settled(fb_modulus_settled), .bank_image(bank_image),
	.fields(fields), .ratios(ratios));
